/* File: src/pmx_exec.sv */
// Functional notes
// RULE_01 - single move: ALU op plus one access
// RULE_02 - dual read: ALU op plus two reads
// RULE_03 - primary and secondary buses used concurrently
// RULE_04 - offset post-update after access completes
// RULE_05 - secondary post-decrement after reads finish
// RULE_06 - parallel move only with ALU operation
// RULE_07 - jump, lea, bitfield with move illegal
// RULE_08 - move part uses restricted registers, modes
// RULE_09 - standalone moves support seven addressing modes
// RULE_10 - dual reads use old pointers, same-cycle load
`timescale 1ns/1ps
`include "pmx_params.svh"
module pmx_exec
  import pmx_pkg::*;
#(
  parameter int W = `PMX_DATA_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         issue_i,
  input  pmx_op_type        op_class_i,
  input  pmx_pm_type        pm_kind_i,
  input  wire logic         pm_write_i,
  input  wire logic [1:0]   pri_ptr_sel_i,
  input  pmx_upd_type       pri_upd_i,
  input  pmx_upd_type       sec_upd_i,
  input  wire logic [1:0]   pri_dst_i,
  input  wire logic [1:0]   sec_dst_i,
  input  wire logic [W-1:0] store_data_i,
  input  wire logic         mv_en_i,
  input  pmx_am_type        mv_mode_i,
  input  wire logic [W-1:0] mv_abs_i,
  input  wire logic [W-1:0] core_global_data_bus_i,
  input  wire logic [W-1:0] secondary_x_data_bus_i,
  input  wire logic         ofs_load_i,
  input  wire logic [W-1:0] ofs_data_i,
  output logic      [W-1:0] primary_x_address_bus_o,
  output logic      [W-1:0] secondary_x_address_bus_o,
  output logic              pri_rd_o,
  output logic              pri_wr_o,
  output logic              sec_rd_o,
  output logic      [W-1:0] core_global_data_bus_o,
  output logic              alu_go_o,
  output logic              illegal_o,
  output logic      [W-1:0] pointer_zero_o,
  output logic      [W-1:0] pointer_one_o,
  output logic      [W-1:0] pointer_three_o,
  output logic      [W-1:0] alu_reg_x0_o,
  output logic      [W-1:0] alu_reg_y0_o,
  output logic      [W-1:0] alu_reg_y1_o,
  output logic      [W-1:0] ofs_o
);
  // pointer arithmetic is only sized for this range of words
  if (W < 8 || W > 32) begin : g_bad_width
    $error("pmx_exec: width out of range");
  end

  logic [W-1:0] ptr_q [4];
  logic [W-1:0] ofs_q;
  logic [W-1:0] x0_q;
  logic [W-1:0] y0_q;
  logic [W-1:0] y1_q;
  logic [W-1:0] pri_ptr;
  logic [W-1:0] pri_next;
  logic [W-1:0] sec_next;
  logic [W-1:0] mv_addr;
  logic [W-1:0] mv_next;
  logic         illegal;
  logic         pm_ok;
  logic         bad_class;
  logic         bad_sec_ptr;
  logic         bad_pri_dec;
  logic         bad_dual_wr;
  logic         do_single;
  logic         do_dual;
  logic         do_mv;
  logic         mv_upd;
  logic         pri_load;
  logic         sec_load;
  pmx_upd_type  mv_upd_kind;

  // parallel move only under an ALU op; jump/lea/bit_field_set_instruction refused
  assign pm_ok     = (op_class_i == PMX_OP_ALU);                  // RULE_06
  assign bad_class = pm_kind_i != PMX_PM_NONE && !pm_ok;          // RULE_07
  // move subset: in a dual read pointer three serves only the secondary read,
  // the primary never post-decrements, a dual read never writes
  assign bad_sec_ptr = pm_kind_i == PMX_PM_DUAL
                       && pri_ptr_sel_i == `PMX_SEC_PTR;          // RULE_08
  assign bad_pri_dec = pm_kind_i != PMX_PM_NONE
                       && pri_upd_i == PMX_UPD_DEC;               // RULE_08
  assign bad_dual_wr = pm_kind_i == PMX_PM_DUAL && pm_write_i;    // RULE_08
  assign illegal     = issue_i && (bad_class || bad_sec_ptr
                       || bad_pri_dec || bad_dual_wr);

  assign do_single = issue_i && !illegal && pm_kind_i == PMX_PM_SINGLE;
  assign do_dual   = issue_i && !illegal && pm_kind_i == PMX_PM_DUAL;
  assign do_mv     = issue_i && op_class_i == PMX_OP_MOVE && mv_en_i
                     && pm_kind_i == PMX_PM_NONE;

  // primary wins a shared destination: its load is written last
  assign pri_load = (do_single || do_mv) && !pm_write_i || do_dual;
  assign sec_load = do_dual;

  // old pointer values drive both addresses
  assign pri_ptr = ptr_q[pri_ptr_sel_i];                         // RULE_10

  // standalone move: seven modes, address side
  always_comb begin
    case (mv_mode_i)                                             // RULE_09
      PMX_AM_IND:       mv_addr = pri_ptr;
      PMX_AM_POSTINC:   mv_addr = pri_ptr;
      PMX_AM_POSTDEC:   mv_addr = pri_ptr;
      PMX_AM_POSTOFS:   mv_addr = pri_ptr;
      PMX_AM_IDX_OFS:   mv_addr = pri_ptr + ofs_q;
      PMX_AM_IDX_SHORT: mv_addr = pri_ptr + mv_abs_i;
      PMX_AM_ABS:       mv_addr = mv_abs_i;
      default:          mv_addr = pri_ptr;
    endcase
  end

  // post-update side of the same seven modes
  always_comb begin
    case (mv_mode_i)                                             // RULE_09
      PMX_AM_IND:       mv_upd_kind = PMX_UPD_NONE;
      PMX_AM_POSTINC:   mv_upd_kind = PMX_UPD_INC;
      PMX_AM_POSTDEC:   mv_upd_kind = PMX_UPD_DEC;
      PMX_AM_POSTOFS:   mv_upd_kind = PMX_UPD_OFS;
      PMX_AM_IDX_OFS:   mv_upd_kind = PMX_UPD_NONE;
      PMX_AM_IDX_SHORT: mv_upd_kind = PMX_UPD_NONE;
      PMX_AM_ABS:       mv_upd_kind = PMX_UPD_NONE;
      default:          mv_upd_kind = PMX_UPD_NONE;
    endcase
  end
  assign mv_upd = do_mv && mv_upd_kind != PMX_UPD_NONE;

  // one adder per pointer path keeps both updates in one cycle
  pmx_ptr_update #(.W(W)) u_pri (
    .ptr_i  (pri_ptr),
    .ofs_i  (ofs_q),
    .upd_i  (pri_upd_i),
    .next_o (pri_next)
  );
  pmx_ptr_update #(.W(W)) u_sec (
    .ptr_i  (ptr_q[3]),
    .ofs_i  (ofs_q),
    .upd_i  (sec_upd_i),
    .next_o (sec_next)
  );
  pmx_ptr_update #(.W(W)) u_mv (
    .ptr_i  (pri_ptr),
    .ofs_i  (ofs_q),
    .upd_i  (mv_upd_kind),
    .next_o (mv_next)
  );

  // access phase: combinational strobes, same cycle as issue
  // memory must answer within the issue cycle, no wait states
  always_comb begin
    primary_x_address_bus_o   = pri_ptr;                         // RULE_03
    secondary_x_address_bus_o = ptr_q[3];                        // RULE_03
    pri_rd_o = (do_single && !pm_write_i) || do_dual            // RULE_01
               || (do_mv && !pm_write_i);
    pri_wr_o = (do_single || do_mv) && pm_write_i;               // RULE_01
    sec_rd_o = do_dual;                                          // RULE_02
    core_global_data_bus_o = pm_write_i ? store_data_i : '0;
    if (do_mv)
      primary_x_address_bus_o = mv_addr;
  end
  assign alu_go_o  = issue_i && !illegal && op_class_i == PMX_OP_ALU;
  assign illegal_o = illegal;

  // pointer write-back at cycle end, after the access
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 4; i++) ptr_q[i] <= W'(`PMX_PTR_RST);
    end else begin
      if (do_single || do_dual)
        ptr_q[pri_ptr_sel_i] <= pri_next;                        // RULE_04
      else if (mv_upd)
        ptr_q[pri_ptr_sel_i] <= mv_next;
      if (do_dual)
        ptr_q[3] <= sec_next;                                    // RULE_05
    end
  end

  // offset only changes on an explicit load
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) ofs_q <= W'(`PMX_OFS_RST);
    else if (ofs_load_i) ofs_q <= ofs_data_i;
  end

  // both loads land on the same edge; primary wins on a clash
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      x0_q <= W'(`PMX_REG_RST);
      y0_q <= W'(`PMX_REG_RST);
      y1_q <= W'(`PMX_REG_RST);
    end else begin
      if (sec_load) begin                                        // RULE_10
        case (sec_dst_i)
          2'd0:    x0_q <= secondary_x_data_bus_i;
          2'd1:    y0_q <= secondary_x_data_bus_i;
          default: y1_q <= secondary_x_data_bus_i;
        endcase
      end
      if (pri_load) begin                                        // RULE_10
        case (pri_dst_i)
          2'd0:    x0_q <= core_global_data_bus_i;
          2'd1:    y0_q <= core_global_data_bus_i;
          default: y1_q <= core_global_data_bus_i;
        endcase
      end
    end
  end

  // pointer two stays internal; nothing outside reads it
  assign pointer_zero_o  = ptr_q[0];
  assign pointer_one_o   = ptr_q[1];
  assign pointer_three_o = ptr_q[3];
  assign alu_reg_x0_o    = x0_q;
  assign alu_reg_y0_o    = y0_q;
  assign alu_reg_y1_o    = y1_q;
  assign ofs_o           = ofs_q;
endmodule : pmx_exec

/* File: src/pmx_params.svh */
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH
`define PMX_DATA_W      16
`define PMX_PTR_RST     16'h0000
`define PMX_OFS_RST     16'h0000
`define PMX_REG_RST     16'h0000
`define PMX_SEC_PTR     2'h3
`define PMX_CYCLE_NS    10
`define PMX_NUM_MODES   7
`endif

/* File: src/pmx_pkg.sv */
package pmx_pkg;
  // main operation class
  typedef enum logic [2:0] {
    PMX_OP_ALU,
    PMX_OP_JUMP,
    PMX_OP_LEA,
    PMX_OP_BIT_FIELD_SET_INSTRUCTION,
    PMX_OP_MOVE,
    PMX_OP_OTHER
  } pmx_op_type;
  // parallel move kind
  typedef enum logic [1:0] {
    PMX_PM_NONE,
    PMX_PM_SINGLE,
    PMX_PM_DUAL
  } pmx_pm_type;
  // post update of a pointer
  typedef enum logic [1:0] {
    PMX_UPD_NONE,
    PMX_UPD_INC,
    PMX_UPD_DEC,
    PMX_UPD_OFS
  } pmx_upd_type;
  // standalone move addressing modes
  typedef enum logic [2:0] {
    PMX_AM_IND,
    PMX_AM_POSTINC,
    PMX_AM_POSTDEC,
    PMX_AM_POSTOFS,
    PMX_AM_IDX_OFS,
    PMX_AM_IDX_SHORT,
    PMX_AM_ABS
  } pmx_am_type;
endpackage : pmx_pkg

/* File: src/pmx_ptr_update.sv */
`timescale 1ns/1ps
module pmx_ptr_update
  import pmx_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [W-1:0] ptr_i,
  input  wire logic [W-1:0] ofs_i,
  input  pmx_upd_type       upd_i,
  output logic      [W-1:0] next_o
);
  if (W < 1) begin : g_bad_width
    $error("pmx_ptr_update: width out of range");
  end

  always_comb begin
    case (upd_i)
      PMX_UPD_INC: next_o = ptr_i + W'(1);
      PMX_UPD_DEC: next_o = ptr_i - W'(1);
      PMX_UPD_OFS: next_o = ptr_i + ofs_i;
      default:     next_o = ptr_i;
    endcase
  end
endmodule : pmx_ptr_update

/* File: testbench/pmx_mem_model.sv */
`timescale 1ns/1ps
module pmx_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] a1_i,
  input  wire logic [15:0] a2_i,
  input  wire logic        rd1_i,
  input  wire logic        rd2_i,
  output logic      [15:0] d1_o,
  output logic      [15:0] d2_o
);
  logic [15:0] junk_q = 16'h0000;
  // idle buses churn so stale data never passes
  always @(posedge ref_clk_i) junk_q <= junk_q + 16'h0001;
  assign d1_o = rd1_i ? a1_i ^ 16'h5A5A : junk_q;
  assign d2_o = rd2_i ? ~a2_i : ~junk_q;
endmodule : pmx_mem_model

/* File: testbench/pmx_exec_assertions.sv */
`timescale 1ns/1ps
module pmx_exec_assertions
  import pmx_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        issue_i,
  input  wire logic        illegal_o,
  input  wire logic        alu_go_o,
  input  wire logic        pri_rd_o,
  input  wire logic        pri_wr_o,
  input  wire logic        sec_rd_o,
  input  wire logic        pm_write_i,
  input  wire logic        mv_en_i,
  input  pmx_op_type       op_class_i,
  input  pmx_pm_type       pm_kind_i,
  input  pmx_upd_type      pri_upd_i,
  input  pmx_upd_type      sec_upd_i,
  input  pmx_am_type       mv_mode_i,
  input  wire logic [1:0]  pri_ptr_sel_i,
  input  wire logic [15:0] mv_abs_i,
  input  wire logic [15:0] primary_x_address_bus_o,
  input  wire logic [15:0] secondary_x_address_bus_o,
  input  wire logic [15:0] pointer_zero_o,
  input  wire logic [15:0] pointer_three_o,
  input  wire logic [15:0] ofs_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic ok, sgl, dual;
  assign ok = issue_i && !illegal_o && op_class_i == PMX_OP_ALU;
  assign sgl = ok && pm_kind_i == PMX_PM_SINGLE;
  assign dual = ok && pm_kind_i == PMX_PM_DUAL;
  single_access_a: assert property (
    sgl |-> alu_go_o && !sec_rd_o && pri_rd_o != pri_wr_o)
    else $error("single move strobes");
  dual_buses_a: assert property (
    dual |-> alu_go_o && pri_rd_o && sec_rd_o) else $error("dual strobes");
  dual_old_ptr_a: assert property (
    dual && pri_ptr_sel_i == 2'h0 |-> primary_x_address_bus_o ==
    pointer_zero_o && secondary_x_address_bus_o == pointer_three_o)
    else $error("dual address");
  single_old_ptr_a: assert property (
    sgl && pri_ptr_sel_i == 2'h0 |-> primary_x_address_bus_o ==
    pointer_zero_o) else $error("single address");
  sec_dec_a: assert property (
    dual && sec_upd_i == PMX_UPD_DEC |=> pointer_three_o ==
    $past(pointer_three_o) - 16'h0001) else $error("secondary decrement");
  ofs_post_a: assert property (
    (sgl || dual) && pri_ptr_sel_i == 2'h0 && pri_upd_i == PMX_UPD_OFS |=>
    pointer_zero_o == $past(pointer_zero_o) + $past(ofs_o))
    else $error("offset update");
  move_alu_a: assert property (
    issue_i && pm_kind_i != PMX_PM_NONE && op_class_i != PMX_OP_ALU |->
    illegal_o && !alu_go_o) else $error("move without alu");
  refused_quiet_a: assert property (
    issue_i && illegal_o |-> !pri_rd_o && !pri_wr_o && !sec_rd_o ##1
    $stable(pointer_zero_o)) else $error("refused op acted");
  move_subset_a: assert property (
    issue_i && pm_kind_i != PMX_PM_NONE && (pri_upd_i == PMX_UPD_DEC ||
    (pm_kind_i == PMX_PM_DUAL && (pri_ptr_sel_i == 2'h3 || pm_write_i))) |->
    illegal_o && !alu_go_o) else $error("restricted move accepted");
  move_abs_a: assert property (
    issue_i && op_class_i == PMX_OP_MOVE && mv_en_i &&
    pm_kind_i == PMX_PM_NONE && mv_mode_i == PMX_AM_ABS |->
    primary_x_address_bus_o == mv_abs_i && pri_rd_o != pri_wr_o)
    else $error("absolute move address");
  cover property (dual && sec_upd_i == PMX_UPD_DEC);
  cover property (sgl && pri_wr_o);
  cover property (issue_i && illegal_o);
  cover property (issue_i && op_class_i == PMX_OP_MOVE && mv_en_i);
endmodule : pmx_exec_assertions
bind pmx_exec pmx_exec_assertions i_chk (.*);

/* File: testbench/parallel_move_execution_test.sv */
`timescale 1ns/1ps
module parallel_move_execution_test;
  import pmx_pkg::*;
  logic ref_clk_i = 0, rstn_i = 0, issue_i = 0, pm_write_i = 0, ofs_load_i = 0;
  logic pri_rd_o, pri_wr_o, sec_rd_o, alu_go_o, illegal_o;
  pmx_op_type op_class_i = PMX_OP_ALU;
  pmx_pm_type pm_kind_i = PMX_PM_DUAL;
  pmx_upd_type pri_upd_i = PMX_UPD_INC, sec_upd_i = PMX_UPD_DEC;
  logic [1:0] pri_ptr_sel_i = 0;
  logic [15:0] store_data_i = 0, ofs_data_i = 0, ofs_o, e0 = 0, e3 = 0, st;
  logic [15:0] core_global_data_bus_i, secondary_x_data_bus_i;
  logic [15:0] primary_x_address_bus_o, secondary_x_address_bus_o;
  logic [15:0] core_global_data_bus_o, pointer_zero_o, pointer_three_o;
  logic [15:0] alu_reg_x0_o, alu_reg_y0_o;
  logic [1:0] pri_dst_i = 2'h1, sec_dst_i = 2'h0;
  logic mv_en_i = 0;
  pmx_am_type mv_mode_i = PMX_AM_IND;
  logic [15:0] mv_abs_i = 0, pointer_one_o, alu_reg_y1_o, e1 = 0, ea, sv;
  int mismatches = 0, n_tests = 0;
  assign st = {13'h0, pri_rd_o, pri_wr_o, sec_rd_o};
  pmx_exec i_dut (.*);
  pmx_mem_model i_mem (.ref_clk_i, .a1_i(primary_x_address_bus_o),
    .a2_i(secondary_x_address_bus_o), .rd1_i(pri_rd_o), .rd2_i(sec_rd_o),
    .d1_o(core_global_data_bus_i), .d2_o(secondary_x_data_bus_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [15:0] exp_addr(pmx_am_type m,
    logic [15:0] p, logic [15:0] o, logic [15:0] a);
    case (m)
      PMX_AM_IDX_OFS:   return p + o;
      PMX_AM_IDX_SHORT: return p + a;
      PMX_AM_ABS:       return a;
      default:          return p;
    endcase
  endfunction : exp_addr
  function automatic logic [15:0] exp_ptr(pmx_am_type m,
    logic [15:0] p, logic [15:0] o);
    case (m)
      PMX_AM_POSTINC: return p + 16'h0001;
      PMX_AM_POSTDEC: return p - 16'h0001;
      PMX_AM_POSTOFS: return p + o;
      default:        return p;
    endcase
  endfunction : exp_ptr
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(28));
    repeat (20) @(negedge ref_clk_i);
    rstn_i = 1;
    ofs_load_i = 1;
    ofs_data_i = 16'($urandom);
    @(negedge ref_clk_i);
    ofs_load_i = 0;
    chk("offset", ofs_data_i, ofs_o);
    issue_i = 1;
    repeat (30) begin
      pri_upd_i = $urandom_range(1) ? PMX_UPD_OFS : PMX_UPD_INC;
      sec_upd_i = pmx_upd_type'($urandom_range(2));
      #1 chk("strobes", 16'h5, st);
      @(negedge ref_clk_i);
      chk("y0", e0 ^ 16'h5A5A, alu_reg_y0_o);
      chk("x0", ~e3, alu_reg_x0_o);
      e0 = e0 + (pri_upd_i == PMX_UPD_OFS ? ofs_data_i : 16'h1);
      e3 = e3 + 16'(sec_upd_i == PMX_UPD_INC) - 16'(sec_upd_i == PMX_UPD_DEC);
      chk("ptr0", e0, pointer_zero_o);
      chk("ptr3", e3, pointer_three_o);
    end
    $display("dual read test done");
    pm_kind_i = PMX_PM_SINGLE;
    pri_upd_i = PMX_UPD_OFS;
    for (int w = 1; w >= 0; w--) begin
      pm_write_i = w[0];
      store_data_i = 16'($urandom);
      #1 chk("strobes", w ? 16'h2 : 16'h4, st);
      chk("wdata", w ? store_data_i : 16'h0, core_global_data_bus_o);
      @(negedge ref_clk_i);
      if (!w[0]) chk("y0", e0 ^ 16'h5A5A, alu_reg_y0_o);
      e0 = e0 + ofs_data_i;
      chk("ptr0", e0, pointer_zero_o);
    end
    $display("single move test done");
    for (int k = 1; k < 6; k++) begin
      op_class_i = pmx_op_type'(k);
      #1 chk("strobes", 16'h0, st);
      chk("refused", 16'h1, {15'h0, illegal_o});
      chk("alu go", 16'h0, {15'h0, alu_go_o});
      @(negedge ref_clk_i);
      chk("ptr0", e0, pointer_zero_o);
    end
    $display("refusal test done");
    op_class_i = PMX_OP_ALU;
    for (int k = 0; k < 3; k++) begin
      pm_kind_i = k == 1 ? PMX_PM_SINGLE : PMX_PM_DUAL;
      pri_ptr_sel_i = k == 0 ? 2'h3 : 2'h0;
      pri_upd_i = k == 1 ? PMX_UPD_DEC : PMX_UPD_INC;
      pm_write_i = k == 2;
      #1 chk("strobes", 16'h0, st);
      chk("refused", 16'h1, {15'h0, illegal_o});
      chk("alu go", 16'h0, {15'h0, alu_go_o});
      @(negedge ref_clk_i);
      chk("ptr0", e0, pointer_zero_o);
      chk("ptr3", e3, pointer_three_o);
    end
    $display("move subset test done");
    pm_kind_i = PMX_PM_SINGLE;
    pm_write_i = 0;
    pri_ptr_sel_i = 2'h1;
    pri_upd_i = PMX_UPD_OFS;
    repeat (6) begin
      pri_dst_i = 2'($urandom_range(2));
      #1 chk("strobes", 16'h4, st);
      chk("alu go", 16'h1, {15'h0, alu_go_o});
      ea = e1 ^ 16'h5A5A;
      @(negedge ref_clk_i);
      sv = pri_dst_i == 2'h0 ? alu_reg_x0_o :
           pri_dst_i == 2'h1 ? alu_reg_y0_o : alu_reg_y1_o;
      chk("load", ea, sv);
      e1 = e1 + ofs_data_i;
      chk("ptr1", e1, pointer_one_o);
    end
    $display("pointer one test done");
    op_class_i = PMX_OP_MOVE;
    pm_kind_i = PMX_PM_NONE;
    mv_en_i = 1;
    pri_dst_i = 2'h2;
    for (int m = 0; m < 7; m++) begin
      mv_mode_i = pmx_am_type'(m);
      mv_abs_i = 16'($urandom);
      ea = exp_addr(mv_mode_i, e1, ofs_data_i, mv_abs_i);
      #1 chk("address", ea, primary_x_address_bus_o);
      chk("strobes", 16'h4, st);
      @(negedge ref_clk_i);
      chk("y1", ea ^ 16'h5A5A, alu_reg_y1_o);
      e1 = exp_ptr(mv_mode_i, e1, ofs_data_i);
      chk("ptr1", e1, pointer_one_o);
    end
    issue_i = 0;
    mv_en_i = 0;
    $display("standalone move test done");
    end_sim();
  end
endmodule : parallel_move_execution_test
